/* logic/aoa_beam_pkg.sv */
// Constants, tables and types of the seven-beam arrival direction former.
// Assumes one 200 MHz clock and a Doppler processor that delivers one line per beat.
// Behaviour
// - Seven beam sums are formed from the four antenna peak values of one height, each antenna's from its own line.
// - Beam 0 is vertical, beams 1-6 oblique at 60 deg azimuth steps from north, zenith 30 deg unless reloaded.
// - All seven beams of a height use the same four samples, one height per pass.
// - Each beam rotates every antenna value to cancel its path delay, then sums the four coherently.
// - The beam with the largest summed amplitude is reported as the arrival direction.
// - Each coefficient has unit magnitude and the negated propagation phase.
// - Antenna 1 sits at the origin and always gets zero correction phase.
// - Coefficients are recomputed at the start of every coherent integration period.
// - X points north, Y west, azimuth 0 is north, spacing is x cos az plus y sin az.
// - Every height gets its own full beam pass and selection, nothing carried over.
// - Each antenna uses only its strongest Doppler line of the height.
// - Phase delay is two pi times sin zenith over wavelength times spacing.
package aoa_beam_pkg;

	// Array sizes and data widths
	localparam int ANT_N      = 4;
	localparam int BEAM_N     = 7;
	localparam int OBL_N      = 6;
	localparam int SAMP_W     = 16;
	localparam int SQ_W       = 32;
	localparam int MAG_W      = 33;
	localparam int COEF_W     = 16;
	localparam int ACC_W      = 36;
	localparam int ACC_SHIFT  = 14;
	localparam int BSUM_W     = 22;
	localparam int BSQ_W      = 44;
	localparam int BMAG_W     = 45;
	localparam int HGT_W      = 10;
	localparam int AMP_W      = 16;
	localparam int AMP_LSB    = 29;
	localparam int BIDX_W     = 3;
	localparam int FIFO_DEPTH = 16;

	// Result word layout
	localparam int RES_BEAM_LSB = 0;
	localparam int RES_HGT_LSB  = 3;
	localparam int RES_AMP_LSB  = 13;
	localparam int RES_W        = BIDX_W + HGT_W + AMP_W;

	// Geometry and phase arithmetic
	localparam int POS_W     = 14;
	localparam int DPROD_W   = 31;
	localparam int TRIG_FRAC = 14;
	localparam int D_W       = 16;
	localparam int ZEN_W     = 16;
	localparam int INVL_W    = 24;
	localparam int KZ_W      = 40;
	localparam int PH_W      = 57;
	localparam int PH_LSB    = 32;
	localparam int ANG_W     = 16;
	localparam int CX_W      = 18;
	localparam int CZ_W      = 17;
	localparam int USQ_W     = 36;

	// Sequencing indices
	localparam logic [2:0] BEAM_VERT = 3'h0;
	localparam logic [2:0] BEAM_LAST = 3'h6;
	localparam logic [1:0] ANT_REF   = 2'h0;
	localparam logic [1:0] ANT_LAST  = 2'h3;
	localparam logic [2:0] CB_LAST   = 3'h5;
	localparam logic [1:0] CA_LAST   = 2'h2;
	localparam logic [3:0] IT_LOAD   = 4'h0;
	localparam logic [3:0] IT_STORE  = 4'hF;

	// Fixed values: unity coefficient Q1.14, sin 30 deg Q0.16, CORDIC start 1/K
	localparam logic signed [COEF_W-1:0] COEF_ONE        = 16'sh4000;
	localparam logic        [ZEN_W-1:0]  SIN_ZEN_DEFAULT = 16'h8000;
	localparam logic        [ANG_W-1:0]  HALF_TURN       = 16'h8000;
	localparam logic signed [CX_W-1:0]   CORDIC_X0       = 18'sh026DD;
	localparam logic        [USQ_W-1:0]  UNIT_LO         = 36'h00FF00000;
	localparam logic        [USQ_W-1:0]  UNIT_HI         = 36'h010100000;

	// Antenna positions in cm, antenna 1 at the origin, X north, Y west
	localparam logic signed [POS_W-1:0] ANT_X [ANT_N] = '{14'sh0000, 14'sh0BB8, -14'sh0BB8, 14'sh0000};
	localparam logic signed [POS_W-1:0] ANT_Y [ANT_N] = '{14'sh0000, 14'sh06C4, 14'sh06C4, -14'sh0D88};

	// Beam azimuth cosine and sine, Q1.14, beam 0 vertical
	localparam logic signed [15:0] BEAM_COS [BEAM_N] =
		'{16'sh0000, 16'sh4000, 16'sh2000, -16'sh2000, -16'sh4000, -16'sh2000, 16'sh2000};
	localparam logic signed [15:0] BEAM_SIN [BEAM_N] =
		'{16'sh0000, 16'sh0000, 16'sh376D, 16'sh376D, 16'sh0000, -16'sh376D, -16'sh376D};

	// Arc tangent of 2^-i in units of 2^-16 turn
	localparam logic [ANG_W-1:0] ATAN_TURNS [14] = '{16'h2000, 16'h12E4, 16'h09FB, 16'h0511,
		16'h028B, 16'h0146, 16'h00A3, 16'h0051, 16'h0029, 16'h0014, 16'h000A, 16'h0005,
		16'h0003, 16'h0001};

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_COEF = 2'b01,
		ST_BEAM = 2'b10,
		ST_PUSH = 2'b11
	} bf_state_t;

endpackage

/* logic/aoa_result_fifo.sv */
// Result queue of the beam former: a small first-in first-out buffer.
// Assumes one clock; writer and reader both use valid and ready.
`timescale 1ns/10ps
`default_nettype none
module aoa_result_fifo #(
	parameter int WIDTH = 29,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys_i,
	input  wire logic             nrst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// Honest full and empty from the fill count
	assign in_ready_o  = cnt_q != (AW+1)'(DEPTH);
	assign out_valid_o = cnt_q != '0;
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_q[rd_q];

	// Storage, written only on an accepted push
	always_ff @(posedge clk_sys_i)
	begin
		if (push)
			mem_q[wr_q] <= in_data_i;
	end

	// Pointers and count
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

endmodule
`default_nettype wire

/* logic/aoa_beam_former.sv */
// Seven-beam arrival direction former: keeps each antenna's peak Doppler line,
// forms seven beams per height and queues the strongest beam of each height.
// Assumes inputs synchronous to clk_sys_i and a consumer that drains results.
`timescale 1ns/10ps
`default_nettype none
module aoa_beam_former
	import aoa_beam_pkg::*;
(
	input  wire logic                           clk_sys_i,
	input  wire logic                           nrst_i,
	input  wire logic                           cit_start_i,
	input  wire logic                           zen_load_i,
	input  wire logic [ZEN_W-1:0]               zen_sin_i,
	input  wire logic [INVL_W-1:0]              inv_lambda_i,
	input  wire logic                           line_valid_i,
	output logic                                line_ready_o,
	input  wire logic                           line_last_i,
	input  wire logic [ANT_N-1:0][SAMP_W-1:0]   line_re_i,
	input  wire logic [ANT_N-1:0][SAMP_W-1:0]   line_im_i,
	output logic                                res_valid_o,
	input  wire logic                           res_ready_i,
	output logic      [BIDX_W-1:0]              res_beam_o,
	output logic      [HGT_W-1:0]               res_height_o,
	output logic      [AMP_W-1:0]               res_amp_o
);
	default clocking cb_a @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);

	bf_state_t                  st_q;
	bf_state_t                  st_d;
	logic                       cit_pend_q;
	logic                       first_q;
	logic [ZEN_W-1:0]           zen_q;
	logic [ZEN_W-1:0]           sin_cfg_q;
	logic [INVL_W-1:0]          inv_cfg_q;
	logic [HGT_W-1:0]           height_q;
	logic                       line_fire;
	logic                       go_coef;
	logic                       go_beam;
	logic                       coef_done;
	logic                       beam_done;
	logic                       push_ok;
	logic                       fifo_in_ready;
	logic [RES_W-1:0]           res_word;
	logic [RES_W-1:0]           res_word_o;

	// Lines are taken only between passes and while no reload waits
	assign line_ready_o = (st_q == ST_IDLE) && !cit_pend_q;
	assign line_fire    = line_valid_i && line_ready_o;
	assign go_coef      = (st_q == ST_IDLE) && cit_pend_q;
	assign go_beam      = line_fire && line_last_i;
	assign push_ok      = (st_q == ST_PUSH) && fifo_in_ready;

	// Per-antenna peak line of the current height
	logic signed [SAMP_W-1:0]   pk_re [ANT_N];
	logic signed [SAMP_W-1:0]   pk_im [ANT_N];
	logic        [MAG_W-1:0]    pk_mag [ANT_N];
	logic        [MAG_W-1:0]    in_mag [ANT_N];

	for (genvar a = 0; a < ANT_N; a++)
	begin : g_peak
		logic signed [SAMP_W-1:0] re_w;
		logic signed [SAMP_W-1:0] im_w;
		logic signed [SAMP_W-1:0] re_q;
		logic signed [SAMP_W-1:0] im_q;
		logic        [MAG_W-1:0]  mag_q;
		logic                     take;

		assign re_w      = $signed(line_re_i[a]);
		assign im_w      = $signed(line_im_i[a]);
		assign in_mag[a] = {1'b0, SQ_W'(re_w * re_w)} + {1'b0, SQ_W'(im_w * im_w)};
		assign take      = first_q || (in_mag[a] > pk_mag[a]);
		assign pk_re[a]  = re_q;
		assign pk_im[a]  = im_q;
		assign pk_mag[a] = mag_q;

		// Keep the line of largest amplitude, first line of a height always taken
		always_ff @(posedge clk_sys_i or negedge nrst_i)
		begin
			if (!nrst_i)
			begin
				re_q  <= '0;
				im_q  <= '0;
				mag_q <= '0;
			end
			else if (line_fire && take)
			begin
				re_q  <= re_w;
				im_q  <= im_w;
				mag_q <= in_mag[a];
			end
		end
	end

	a_line_peak: assert property (
		line_fire && !first_q
		|=> (pk_mag[0] == ($past(in_mag[0]) > $past(pk_mag[0]) ? $past(in_mag[0]) : $past(pk_mag[0]))))
		else $error("peak line of antenna 1 not tracked");

	// Next state
	always_comb
	begin
		st_d = st_q;
		case (st_q)
			ST_IDLE:
				if (go_coef)
					st_d = ST_COEF;
				else if (go_beam)
					st_d = ST_BEAM;
			ST_COEF:
				if (coef_done)
					st_d = ST_IDLE;
			ST_BEAM:
				if (beam_done)
					st_d = ST_PUSH;
			ST_PUSH:
				if (push_ok)
					st_d = ST_IDLE;
			default:
				st_d = ST_IDLE;
		endcase
	end

	// Control: state, pending reload, zenith setting, height count
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_q       <= ST_IDLE;
			cit_pend_q <= 1'b0;
			first_q    <= 1'b1;
			zen_q      <= SIN_ZEN_DEFAULT;
			sin_cfg_q  <= SIN_ZEN_DEFAULT;
			inv_cfg_q  <= '0;
			height_q   <= '0;
		end
		else
		begin
			st_q       <= st_d;
			cit_pend_q <= cit_start_i || (cit_pend_q && !go_coef);
			if (zen_load_i)
				zen_q <= zen_sin_i;
			if (go_coef)
			begin
				sin_cfg_q <= zen_q;
				inv_cfg_q <= inv_lambda_i;
			end
			if (line_fire)
				first_q <= 1'b0;
			else if (go_coef || push_ok)
				first_q <= 1'b1;
			if (go_coef)
				height_q <= '0;
			else if (push_ok)
				height_q <= height_q + 1'b1;
		end
	end

	a_cit_taken: assert property (
		cit_start_i && (st_q == ST_IDLE) && !line_fire
		|=> !line_ready_o ##1 (st_q == ST_COEF))
		else $error("coherent period start did not begin a reload");

	a_height_step: assert property (
		push_ok |=> (st_q == ST_IDLE) && first_q && (height_q == $past(height_q) + 1'b1))
		else $error("height did not advance after a result");

	// Coefficient engine: six oblique beams by three non-reference antennas
	logic [3:0]                 it_q;
	logic [2:0]                 cb_q;
	logic [1:0]                 ca_q;
	logic signed [CX_W-1:0]     cx_q;
	logic signed [CX_W-1:0]     cy_q;
	logic signed [CZ_W-1:0]     cz_q;
	logic signed [COEF_W-1:0]   coef_re_q [OBL_N][ANT_N-1];
	logic signed [COEF_W-1:0]   coef_im_q [OBL_N][ANT_N-1];
	logic [2:0]                 cb1;
	logic [1:0]                 ca1;
	logic signed [DPROD_W-1:0]  dprod;
	logic signed [D_W-1:0]      d_cm;
	logic [KZ_W-1:0]            kz;
	logic signed [PH_W-1:0]     ph;
	logic [ANG_W-1:0]           phase;
	logic [ANG_W-1:0]           ang;
	logic [ANG_W-1:0]           zadj;
	logic                       flip;
	logic [3:0]                 sh_w;
	logic signed [CX_W-1:0]     cx_sh;
	logic signed [CX_W-1:0]     cy_sh;
	logic signed [CZ_W-1:0]     atan_w;
	logic [USQ_W-1:0]           unit_sq;

	// Projected spacing, phase delay in turns and its negation
	assign cb1   = cb_q + 3'h1;
	assign ca1   = ca_q + 2'h1;
	assign dprod = DPROD_W'(ANT_X[ca1] * BEAM_COS[cb1]) + DPROD_W'(ANT_Y[ca1] * BEAM_SIN[cb1]);
	assign d_cm  = dprod[TRIG_FRAC +: D_W];
	assign kz    = sin_cfg_q * inv_cfg_q;
	assign ph    = $signed({1'b0, kz}) * d_cm;
	assign phase = ph[PH_LSB +: ANG_W];
	assign ang   = -phase;
	assign flip  = ang[ANG_W-1] ^ ang[ANG_W-2];
	assign zadj  = flip ? ang - HALF_TURN : ang;

	// One CORDIC micro-rotation per cycle
	assign sh_w    = it_q - 4'h1;
	assign cx_sh   = cx_q >>> sh_w;
	assign cy_sh   = cy_q >>> sh_w;
	assign atan_w  = $signed({1'b0, ATAN_TURNS[sh_w]});
	assign unit_sq = USQ_W'(cx_q * cx_q) + USQ_W'(cy_q * cy_q);
	assign coef_done = (st_q == ST_COEF) && (it_q == IT_STORE) && (cb_q == CB_LAST) && (ca_q == CA_LAST);

	// Sequencing and rotation of (1/K, 0) by the negated phase
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			it_q <= IT_LOAD;
			cb_q <= '0;
			ca_q <= '0;
			cx_q <= '0;
			cy_q <= '0;
			cz_q <= '0;
		end
		else if (go_coef)
		begin
			it_q <= IT_LOAD;
			cb_q <= '0;
			ca_q <= '0;
		end
		else if (st_q == ST_COEF)
		begin
			it_q <= it_q + 4'h1;
			if (it_q == IT_LOAD)
			begin
				cx_q <= flip ? -CORDIC_X0 : CORDIC_X0;
				cy_q <= '0;
				cz_q <= {zadj[ANG_W-1], zadj};
			end
			else if (it_q == IT_STORE)
			begin
				ca_q <= (ca_q == CA_LAST) ? '0 : ca_q + 2'h1;
				if (ca_q == CA_LAST)
					cb_q <= cb_q + 3'h1;
			end
			else if (!cz_q[CZ_W-1])
			begin
				cx_q <= cx_q - cy_sh;
				cy_q <= cy_q + cx_sh;
				cz_q <= cz_q - atan_w;
			end
			else
			begin
				cx_q <= cx_q + cy_sh;
				cy_q <= cy_q - cx_sh;
				cz_q <= cz_q + atan_w;
			end
		end
	end

	// Coefficient table, unity until the first reload
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			for (int b = 0; b < OBL_N; b++)
				for (int k = 0; k < ANT_N-1; k++)
				begin
					coef_re_q[b][k] <= COEF_ONE;
					coef_im_q[b][k] <= '0;
				end
		end
		else if ((st_q == ST_COEF) && (it_q == IT_STORE))
		begin
			coef_re_q[cb_q][ca_q] <= cx_q[COEF_W-1:0];
			coef_im_q[cb_q][ca_q] <= cy_q[COEF_W-1:0];
		end
	end

	sequence s_coef_run;
		##287 (st_q == ST_COEF) ##1 (st_q == ST_IDLE);
	endsequence

	a_coef_reload: assert property (
		go_coef |=> s_coef_run)
		else $error("coefficient reload did not take 288 cycles");

	a_coef_unit: assert property (
		(st_q == ST_COEF) && (it_q == IT_STORE) |-> (unit_sq >= UNIT_LO) && (unit_sq <= UNIT_HI))
		else $error("coefficient magnitude is not one");

	a_spacing_north: assert property (
		(st_q == ST_COEF) && (cb_q == 3'h0) && (ca_q == 2'h0) |-> (d_cm == D_W'(ANT_X[1])))
		else $error("north beam spacing is not the x position");

	// Beam engine: one complex product per cycle, four per beam
	logic [2:0]                 beam_q;
	logic [1:0]                 ant_q;
	logic signed [ACC_W-1:0]    acc_re_q;
	logic signed [ACC_W-1:0]    acc_im_q;
	logic [BMAG_W-1:0]          best_mag_q;
	logic [BIDX_W-1:0]          best_beam_q;
	logic                       unity_w;
	logic signed [COEF_W-1:0]   cr_w;
	logic signed [COEF_W-1:0]   ci_w;
	logic signed [SAMP_W-1:0]   sr_w;
	logic signed [SAMP_W-1:0]   si_w;
	logic signed [ACC_W-1:0]    mul_re;
	logic signed [ACC_W-1:0]    mul_im;
	logic signed [ACC_W-1:0]    nx_re;
	logic signed [ACC_W-1:0]    nx_im;
	logic signed [BSUM_W-1:0]   bre;
	logic signed [BSUM_W-1:0]   bim;
	logic [BMAG_W-1:0]          nmag;
	logic                       better;

	// Coefficient selection, reference antenna and vertical beam stay unrotated
	assign unity_w = (beam_q == BEAM_VERT) || (ant_q == ANT_REF);
	assign cr_w    = unity_w ? COEF_ONE : coef_re_q[beam_q - 3'h1][ant_q - 2'h1];
	assign ci_w    = unity_w ? '0 : coef_im_q[beam_q - 3'h1][ant_q - 2'h1];
	assign sr_w    = pk_re[ant_q];
	assign si_w    = pk_im[ant_q];

	// Rotate and accumulate, then beam power of the finished sum
	assign mul_re = ACC_W'(sr_w * cr_w) - ACC_W'(si_w * ci_w);
	assign mul_im = ACC_W'(sr_w * ci_w) + ACC_W'(si_w * cr_w);
	assign nx_re  = acc_re_q + mul_re;
	assign nx_im  = acc_im_q + mul_im;
	assign bre    = nx_re[ACC_SHIFT +: BSUM_W];
	assign bim    = nx_im[ACC_SHIFT +: BSUM_W];
	assign nmag   = {1'b0, BSQ_W'(bre * bre)} + {1'b0, BSQ_W'(bim * bim)};
	assign better = (beam_q == BEAM_VERT) || (nmag > best_mag_q);
	assign beam_done = (st_q == ST_BEAM) && (beam_q == BEAM_LAST) && (ant_q == ANT_LAST);

	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			beam_q      <= BEAM_VERT;
			ant_q       <= ANT_REF;
			acc_re_q    <= '0;
			acc_im_q    <= '0;
			best_mag_q  <= '0;
			best_beam_q <= BEAM_VERT;
		end
		else if (go_beam)
		begin
			beam_q   <= BEAM_VERT;
			ant_q    <= ANT_REF;
			acc_re_q <= '0;
			acc_im_q <= '0;
		end
		else if (st_q == ST_BEAM)
		begin
			if (ant_q == ANT_LAST)
			begin
				ant_q    <= ANT_REF;
				beam_q   <= beam_q + 3'h1;
				acc_re_q <= '0;
				acc_im_q <= '0;
				if (better)
				begin
					best_mag_q  <= nmag;
					best_beam_q <= beam_q;
				end
			end
			else
			begin
				ant_q    <= ant_q + 2'h1;
				acc_re_q <= nx_re;
				acc_im_q <= nx_im;
			end
		end
	end

	sequence s_beam_pass;
		##27 ((st_q == ST_BEAM) && (beam_q == BEAM_LAST) && (ant_q == ANT_LAST)) ##1 (st_q == ST_PUSH);
	endsequence

	a_beam_pass: assert property (
		$rose(st_q == ST_BEAM) |-> (beam_q == BEAM_VERT) && (ant_q == ANT_REF) ##0 s_beam_pass)
		else $error("beam pass did not cover seven beams of four antennas");

	a_ref_unity: assert property (
		(st_q == ST_BEAM) && (ant_q == ANT_REF) |-> (cr_w == COEF_ONE) && (ci_w == '0))
		else $error("reference antenna was rotated");

	a_strongest: assert property (
		(st_q == ST_BEAM) && (ant_q == ANT_LAST) && (nmag > best_mag_q)
		|=> (best_beam_q == $past(beam_q)) && (best_mag_q == $past(nmag)))
		else $error("stronger beam not selected");

	a_tie_lowest: assert property (
		(st_q == ST_BEAM) && (ant_q == ANT_LAST) && (beam_q != BEAM_VERT) && (nmag == best_mag_q)
		|=> $stable(best_beam_q))
		else $error("tie moved the selection to a higher beam");

	a_vert_first: assert property (
		(st_q == ST_BEAM) && (beam_q == BEAM_VERT) && (ant_q == ANT_LAST)
		|=> (best_beam_q == BEAM_VERT) && (best_mag_q == $past(nmag)))
		else $error("selection carried over from an earlier height");

	// Result word into the queue; a full queue holds the pass in push
	assign res_word = {best_mag_q[AMP_LSB +: AMP_W], height_q, best_beam_q};

	aoa_result_fifo #(
		.WIDTH (RES_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (st_q == ST_PUSH),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (res_word),
		.out_valid_o (res_valid_o),
		.out_ready_i (res_ready_i),
		.out_data_o  (res_word_o)
	);

	// Result fields
	assign res_beam_o   = res_word_o[RES_BEAM_LSB +: BIDX_W];
	assign res_height_o = res_word_o[RES_HGT_LSB +: HGT_W];
	assign res_amp_o    = res_word_o[RES_AMP_LSB +: AMP_W];

endmodule
`default_nettype wire

/* tb/doppler_line_src.sv */
// Model of the upstream Doppler processor: offers one line of four antennas at a time.
// Assumes it shares clk_sys_i with the beam former and sees its line ready output.
`timescale 1ns/10ps
`default_nettype none
module doppler_line_src
	import aoa_beam_pkg::*;
(
	input  wire logic                    clk_sys_i,
	input  wire logic                    line_ready_i,
	output logic                         line_valid_o,
	output logic                         line_last_o,
	output logic [ANT_N-1:0][SAMP_W-1:0] line_re_o,
	output logic [ANT_N-1:0][SAMP_W-1:0] line_im_o
);
	// Idle values at time zero
	initial
	begin
		line_valid_o = 1'b0;
		line_last_o = 1'b0;
		line_re_o = '0;
		line_im_o = '0;
	end

	// Offer a line and hold it until the beam former takes it
	task automatic send(input logic [ANT_N-1:0][SAMP_W-1:0] re, input logic [ANT_N-1:0][SAMP_W-1:0] im,
		input logic last, output logic ok);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		line_valid_o <= 1'b1;
		line_last_o <= last;
		line_re_o <= re;
		line_im_o <= im;
		@(posedge clk_sys_i);
		while (line_ready_i !== 1'b1 && n < 400)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		ok = (line_ready_i === 1'b1);
		// Released data is inverted so stale values cannot pass for a line
		line_valid_o <= 1'b0;
		line_last_o <= 1'b0;
		line_re_o <= ~re;
		line_im_o <= ~im;
	endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench of the seven-beam arrival direction former.
// Assumes the Doppler line model in doppler_line_src and a 200 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
	$display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
module tb_top
	import aoa_beam_pkg::*;
;
	typedef logic [ANT_N-1:0][SAMP_W-1:0] line_t;
	logic               clk_sys_i, nrst_i, cit_start, zen_load, line_valid, line_ready, line_last;
	logic [ZEN_W-1:0]   zen_sin;
	logic [INVL_W-1:0]  inv_lambda;
	line_t              line_re, line_im;
	logic               res_valid, res_ready;
	logic [BIDX_W-1:0]  res_beam;
	logic [HGT_W-1:0]   res_height;
	logic [AMP_W-1:0]   res_amp, last_amp;
	int                 fail_count, check_count, cycles;
	// North arrival: antenna 2 leads a quarter turn, antenna 3 lags it
	localparam line_t   N_RE = 64'h1F40_0000_0000_1F40;
	localparam line_t   N_IM = 64'h0000_E0C0_1F40_0000;
	localparam line_t   S_IM = 64'h0000_1F40_E0C0_0000;
	localparam logic [INVL_W-1:0] INV_Q = 24'h0AEC34;

	aoa_beam_former dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cit_start_i(cit_start),
		.zen_load_i(zen_load), .zen_sin_i(zen_sin), .inv_lambda_i(inv_lambda), .line_valid_i(line_valid),
		.line_ready_o(line_ready), .line_last_i(line_last), .line_re_i(line_re), .line_im_i(line_im),
		.res_valid_o(res_valid), .res_ready_i(res_ready), .res_beam_o(res_beam),
		.res_height_o(res_height), .res_amp_o(res_amp));
	doppler_line_src src_u (.clk_sys_i(clk_sys_i), .line_ready_i(line_ready), .line_valid_o(line_valid),
		.line_last_o(line_last), .line_re_o(line_re), .line_im_o(line_im));

	// Clock and hang guard
	always #2.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 12000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		if (fail_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Expected value of the amplitude field for summed components
	function automatic logic [AMP_W-1:0] amp_of(input longint sr, input longint si);
		return AMP_W'((sr * sr + si * si) >> AMP_LSB);
	endfunction

	task automatic send(input line_t re, input line_t im, input logic last);
		logic ok;
		src_u.send(re, im, last, ok);
		`CHK("line taken", 1'b1, ok)
	endtask

	// Take one result word and judge beam and height
	task automatic get(input logic [BIDX_W-1:0] b, input logic [HGT_W-1:0] h);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		res_ready <= 1'b1;
		@(posedge clk_sys_i);
		while (res_valid !== 1'b1 && n < 400)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		`CHK("result valid", 1'b1, res_valid)
		`CHK("beam", b, res_beam)
		`CHK("height", h, res_height)
		last_amp = res_amp;
		res_ready <= 1'b0;
	endtask

	// Start a coherent integration period and wait for coefficients
	task automatic reload(input logic [INVL_W-1:0] inv);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		cit_start <= 1'b1;
		inv_lambda <= inv;
		@(posedge clk_sys_i);
		cit_start <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		`CHK("ready in reload", 1'b0, line_ready)
		while (line_ready !== 1'b1 && n < 400)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		`CHK("ready after reload", 1'b1, line_ready)
	endtask

	task automatic load_zenith(input logic [ZEN_W-1:0] z);
		@(posedge clk_sys_i);
		zen_load <= 1'b1;
		zen_sin <= z;
		@(posedge clk_sys_i);
		zen_load <= 1'b0;
	endtask

	// Unity coefficients: peak line per antenna kept, heights counted
	task automatic t_unity();
		send(64'h03E8_03E8_03E8_03E8, 64'h03E8_03E8_03E8_03E8, 1'b0);
		send(64'h000A_000A_3E80_3E80, 64'h000A_000A_3E80_3E80, 1'b1);
		get(3'h0, 10'h000);
		`CHK("peak amplitude", amp_of(34000, 34000), last_amp)
		send(64'h3E80_3E80_3E80_3E80, 64'h3E80_3E80_3E80_3E80, 1'b1);
		get(3'h0, 10'h001);
		`CHK("sum amplitude", amp_of(64000, 64000), last_amp)
	endtask

	// Steered coefficients: north and south arrivals, height restarts
	task automatic t_direction();
		reload(INV_Q);
		send(N_RE, N_IM, 1'b1);
		get(3'h1, 10'h000);
		send(N_RE, S_IM, 1'b1);
		get(3'h4, 10'h001);
		// Only the reference antenna lit: every beam sums the same, so the tie goes to beam 0
		send(64'h0000_0000_0000_7D00, 64'h0000_0000_0000_7D00, 1'b1);
		get(3'h0, 10'h002);
		`CHK("reference amplitude", amp_of(32000, 32000), last_amp)
	endtask

	// Zero zenith gives equal beams, the vertical one wins
	task automatic t_zenith();
		load_zenith(16'h0000);
		reload(INV_Q);
		send(N_RE, N_IM, 1'b1);
		get(3'h0, 10'h000);
		load_zenith(SIN_ZEN_DEFAULT);
	endtask

	// Fill the result queue until it refuses, then drain in order
	task automatic t_fifo();
		reload(INV_Q);
		for (int i = 0; i <= FIFO_DEPTH; i++)
			send(64'h1F40_1F40_1F40_1F40, 64'h0000_0000_0000_0000, 1'b1);
		repeat (40) @(posedge clk_sys_i);
		`CHK("ready with full queue", 1'b0, line_ready)
		`CHK("queue valid", 1'b1, res_valid)
		for (int i = 0; i <= FIFO_DEPTH; i++)
			get(3'h0, HGT_W'(i));
	endtask

	initial
	begin
		clk_sys_i = 1'b0;
		nrst_i = 1'b0;
		cit_start = 1'b0;
		zen_load = 1'b0;
		zen_sin = SIN_ZEN_DEFAULT;
		inv_lambda = '0;
		res_ready = 1'b0;
		fail_count = 0;
		check_count = 0;
		cycles = 0;
		repeat (16) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		@(posedge clk_sys_i);
		`CHK("ready after reset", 1'b1, line_ready)
		`CHK("valid after reset", 1'b0, res_valid)
		t_unity();
		t_direction();
		t_zenith();
		t_fifo();
		tally_and_finish();
	end
endmodule
`undef CHK
`default_nettype wire
